//--- rtl/csd_axil_slave.sv
// axi4-lite slave front end for the decoder registers
`timescale 1ns/1ps
module csd_axil_slave
   import csd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [CSD_AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CSD_AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output csd_wreq_type wreq,
   output csd_rreq_type rreq
);
   typedef struct packed {
      logic aw_full;
      logic [CSD_AXI_ADDR_W-1:0] awaddr;
      logic w_full;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic rd_pend;
      logic [CSD_AXI_ADDR_W-1:0] araddr;
      logic rvalid;
   } csd_slv_state_type;

   csd_slv_state_type s_reg;
   csd_slv_state_type s_next;
   logic wr_fire;

   assign s_axi_awready = !s_reg.aw_full;
   assign s_axi_wready = !s_reg.w_full;
   assign s_axi_arready = !s_reg.rd_pend && !s_reg.rvalid;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_bresp = CSD_RESP_OKAY;
   assign s_axi_rresp = CSD_RESP_OKAY;
   assign wr_fire = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
   assign wreq = '{en: wr_fire, addr: s_reg.awaddr, data: s_reg.wdata, strb: s_reg.wstrb};
   assign rreq = '{en: s_reg.rd_pend, addr: s_reg.araddr};

   always_comb
   begin
      s_next = s_reg;
      // address and data taken in either order
      if (s_axi_awvalid && !s_reg.aw_full)
      begin
         s_next.aw_full = 1'b1;
         s_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_reg.w_full)
      begin
         s_next.w_full = 1'b1;
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         s_next.aw_full = 1'b0;
         s_next.w_full = 1'b0;
         s_next.bvalid = 1'b1;
      end
      else if (s_reg.bvalid && s_axi_bready)
      begin
         s_next.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_reg.rd_pend && !s_reg.rvalid)
      begin
         s_next.rd_pend = 1'b1;
         s_next.araddr = s_axi_araddr;
      end
      // read data registered in the main block during rd_pend
      if (s_reg.rd_pend)
      begin
         s_next.rd_pend = 1'b0;
         s_next.rvalid = 1'b1;
      end
      else if (s_reg.rvalid && s_axi_rready)
      begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end
endmodule : csd_axil_slave

//--- rtl/csd_chip_select_decode.sv
// chip-select address decoder with wait-state termination
// How it works
// - low three base bits hold block-size code
// - codes select 2K..1M blocks, compare width
// - only upper address bits are compared
// - base bits below block boundary read zero
// - match needs both base and block size
// - several chip-selects may match, no error
// - own option register sets wait states
// - earliest termination among matches ends cycle
// - strap low at reset makes acks general I/O
`timescale 1ns/1ps
module csd_chip_select_decode
   import csd_pkg::*;
#(
   parameter int CS_COUNT = 12
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [CSD_AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CSD_AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cycle_start,
   input wire logic [CSD_ADDR_W-1:0] cycle_addr,
   output logic [CS_COUNT-1:0] chip_select_n,
   output logic cycle_done,
   output logic cycle_hit,
   input wire logic reset_config_line_eight,
   input wire logic size_ack_high_in,
   output logic size_ack_high_out,
   output logic size_ack_high_oe,
   input wire logic size_ack_low_in,
   output logic size_ack_low_out,
   output logic size_ack_low_oe
);
   localparam int IDX_W = (CS_COUNT > 1) ? $clog2(CS_COUNT) : 1;
   localparam logic [11:0] CS_SPAN = 12'(CS_COUNT * 8);

   typedef struct packed {
      logic [CS_COUNT-1:0][15:0] base;
      logic [CS_COUNT-1:0][15:0] opt;
      logic pin_assign;
      logic [3:0] gpio;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [31:0] rdata;
      csd_cycle_type state;
      logic [CSD_WAIT_W-1:0] count;
      logic [CSD_WAIT_W-1:0] target;
      logic port16;
      logic [CS_COUNT-1:0] match;
      logic [CS_COUNT-1:0] last_match;
      logic done;
      logic hit;
      logic ack_high;
      logic ack_low;
   } csd_state_type;

   csd_state_type s_reg;
   csd_state_type s_next;
   csd_wreq_type wreq;
   csd_rreq_type rreq;
   logic [CS_COUNT-1:0] mvec;
   logic [CSD_WAIT_W-1:0] mvec_wait;
   logic mvec_p16;
   logic [15:0] wval;
   logic [IDX_W-1:0] widx;
   logic [IDX_W-1:0] ridx;

   csd_axil_slave i_csd_axil_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wreq(wreq),
      .rreq(rreq)
   );

   assign widx = wreq.addr[CSD_CS_IDX_LSB +: IDX_W];
   assign ridx = rreq.addr[CSD_CS_IDX_LSB +: IDX_W];

   // parallel compare of the bus address against every chip-select
   always_comb
   begin
      mvec = '0;
      mvec_wait = CSD_WAIT_MAX;
      mvec_p16 = 1'b0;
      for (int i = 0; i < CS_COUNT; i++)
      begin
         if (s_reg.opt[i][CSD_ENABLE_BIT] &&
             ((cycle_addr[CSD_ADDR_W-1:CSD_ADDR_CMP_LSB] & csd_field_mask(s_reg.base[i][2:0])) ==
              s_reg.base[i][15:CSD_FIELD_LSB]))
         begin
            mvec[i] = 1'b1;
            mvec_p16 = mvec_p16 | s_reg.opt[i][CSD_PORT16_BIT];
            if (s_reg.opt[i][CSD_WAIT_LSB +: CSD_WAIT_W] < mvec_wait)
            begin
               mvec_wait = s_reg.opt[i][CSD_WAIT_LSB +: CSD_WAIT_W];
            end
         end
      end
   end

   always_comb
   begin
      s_next = s_reg;
      wval = 16'h0000;
      s_next.sync1 = {size_ack_low_in, size_ack_high_in, reset_config_line_eight};
      s_next.sync2 = s_reg.sync1;
      s_next.done = 1'b0;
      s_next.ack_high = 1'b0;
      s_next.ack_low = 1'b0;
      if (wreq.en)
      begin
         if (wreq.addr < CS_SPAN && wreq.addr[1:0] == 2'h0)
         begin
            if (wreq.addr[2] == CSD_BASE_OFS[2])
            begin
               wval = csd_apply_strb(s_reg.base[widx], wreq.data, wreq.strb);
               // aligned to block size when stored
               s_next.base[widx] = {wval[15:CSD_FIELD_LSB] & csd_field_mask(wval[2:0]),
                                    wval[CSD_CODE_LSB +: CSD_CODE_W]};
            end
            else
            begin
               s_next.opt[widx] = csd_apply_strb(s_reg.opt[widx], wreq.data, wreq.strb);
            end
         end
         else if (wreq.addr == CSD_PIN_ASSIGN_OFS && wreq.strb[0])
         begin
            s_next.pin_assign = wreq.data[CSD_SIZE_ACK_FN_BIT];
         end
         else if (wreq.addr == CSD_GPIO_OFS && wreq.strb[0])
         begin
            s_next.gpio = wreq.data[3:0];
         end
      end
      if (rreq.en)
      begin
         s_next.rdata = 32'h0000_0000;
         if (rreq.addr < CS_SPAN && rreq.addr[1:0] == 2'h0)
         begin
            s_next.rdata[15:0] = (rreq.addr[2] == CSD_BASE_OFS[2]) ? s_reg.base[ridx] : s_reg.opt[ridx];
         end
         else if (rreq.addr == CSD_PIN_ASSIGN_OFS)
         begin
            s_next.rdata[CSD_SIZE_ACK_FN_BIT] = s_reg.pin_assign;
         end
         else if (rreq.addr == CSD_GPIO_OFS)
         begin
            s_next.rdata[3:0] = s_reg.gpio;
         end
         else if (rreq.addr == CSD_STATUS_OFS)
         begin
            s_next.rdata[3:0] = {s_reg.sync2[2:1], s_reg.hit, s_reg.state == CSD_ACTIVE};
         end
         else if (rreq.addr == CSD_MATCH_OFS)
         begin
            s_next.rdata[CS_COUNT-1:0] = s_reg.last_match;
         end
      end
      case (s_reg.state)
         CSD_IDLE:
         begin
            if (cycle_start)
            begin
               s_next.match = mvec;
               s_next.last_match = mvec;
               s_next.target = mvec_wait;
               s_next.port16 = mvec_p16;
               s_next.count = '0;
               s_next.state = CSD_ACTIVE;
            end
         end
         CSD_ACTIVE:
         begin
            if (s_reg.match == '0)
            begin
               s_next.done = 1'b1;
               s_next.hit = 1'b0;
               s_next.state = CSD_IDLE;
            end
            else if (s_reg.count == s_reg.target)
            begin
               s_next.done = 1'b1;
               s_next.hit = 1'b1;
               s_next.ack_high = s_reg.port16;
               s_next.ack_low = !s_reg.port16;
               s_next.match = '0;
               s_next.state = CSD_IDLE;
            end
            else
            begin
               s_next.count = s_reg.count + 4'h1;
            end
         end
         default:
         begin
            s_next.state = CSD_IDLE;
            s_next.match = '0;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_reg.base <= {CS_COUNT{CSD_BASE_RST}};
         s_reg.opt <= {CS_COUNT{CSD_OPT_RST}};
         s_reg.gpio <= CSD_GPIO_RST;
         s_reg.rdata <= 32'h0000_0000;
         s_reg.state <= CSD_IDLE;
         s_reg.count <= '0;
         s_reg.target <= '0;
         s_reg.port16 <= 1'b0;
         s_reg.match <= '0;
         s_reg.last_match <= '0;
         s_reg.done <= 1'b0;
         s_reg.hit <= 1'b0;
         s_reg.ack_high <= 1'b0;
         s_reg.ack_low <= 1'b0;
         // strap kept sampling while reset is held
         s_reg.sync1 <= s_next.sync1;
         s_reg.sync2 <= s_next.sync2;
         s_reg.pin_assign <= s_reg.sync2[0];
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign s_axi_rdata = s_reg.rdata;
   assign chip_select_n = ~s_reg.match;
   assign cycle_done = s_reg.done;
   assign cycle_hit = s_reg.hit;
   // open-drain acks or general i/o
   assign size_ack_high_out = s_reg.pin_assign ? 1'b0 : s_reg.gpio[CSD_GPIO_OUT_LSB];
   assign size_ack_high_oe = s_reg.pin_assign ? s_reg.ack_high : s_reg.gpio[CSD_GPIO_DIR_LSB];
   assign size_ack_low_out = s_reg.pin_assign ? 1'b0 : s_reg.gpio[CSD_GPIO_OUT_LSB + 1];
   assign size_ack_low_oe = s_reg.pin_assign ? s_reg.ack_low : s_reg.gpio[CSD_GPIO_DIR_LSB + 1];

   // cycles of chip-select assertion, for checking only
   logic [4:0] cs_len;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || (&chip_select_n))
      begin
         cs_len <= '0;
      end
      else
      begin
         cs_len <= cs_len + 5'h01;
      end
   end

   genvar g;
   for (g = 0; g < CS_COUNT; g++)
   begin : g_chk
      property p_base_aligned;
         @(posedge aclk) disable iff (!aresetn)
         (s_reg.base[g][15:3] & ~csd_field_mask(s_reg.base[g][2:0])) == 13'h0000;
      endproperty
      a_base_aligned: assert property (p_base_aligned) else $error("base bits below block not zero");
      property p_wait_min;
         @(posedge aclk) disable iff (!aresetn)
         (s_reg.state == CSD_IDLE && cycle_start && mvec[g]) |=>
            s_reg.target <= $past(s_reg.opt[g][3:0]);
      endproperty
      a_wait_min: assert property (p_wait_min) else $error("target later than a matching select");
   end

   property p_match_cs0;
      @(posedge aclk) disable iff (!aresetn)
      (s_reg.state == CSD_IDLE && cycle_start && s_reg.opt[0][5] &&
       (cycle_addr[23:11] & csd_field_mask(s_reg.base[0][2:0])) == s_reg.base[0][15:3]) |=> !chip_select_n[0];
   endproperty
   a_match_cs0: assert property (p_match_cs0) else $error("select 0 not asserted on match");

   property p_all_matches;
      @(posedge aclk) disable iff (!aresetn)
      (s_reg.state == CSD_IDLE && cycle_start) |=> (~chip_select_n == $past(mvec));
   endproperty
   a_all_matches: assert property (p_all_matches) else $error("match vector not driven");

   property p_cs_len;
      @(posedge aclk) disable iff (!aresetn)
      (cycle_done && cycle_hit) |-> (cs_len == {1'b0, s_reg.target} + 5'h01) && (&chip_select_n);
   endproperty
   a_cs_len: assert property (p_cs_len) else $error("select length not wait count plus one");

   property p_base_read;
      @(posedge aclk) disable iff (!aresetn)
      (rreq.en && rreq.addr == CSD_BASE_OFS && !wreq.en) |=> s_axi_rdata == {16'h0000, $past(s_reg.base[0])};
   endproperty
   a_base_read: assert property (p_base_read) else $error("base read back wrong");

   property p_no_match_done;
      @(posedge aclk) disable iff (!aresetn)
      (s_reg.state == CSD_IDLE && cycle_start && mvec == '0) |=> ##1 (cycle_done && !cycle_hit);
   endproperty
   a_no_match_done: assert property (p_no_match_done) else $error("unmatched cycle not closed");

   property p_strap;
      @(posedge aclk)
      $rose(aresetn) |-> s_reg.pin_assign == $past(s_reg.sync2[0]);
   endproperty
   a_strap: assert property (p_strap) else $error("strap not captured at reset");

   property p_gpio_mode;
      @(posedge aclk) disable iff (!aresetn)
      !s_reg.pin_assign |-> (size_ack_high_oe == s_reg.gpio[2]) && (size_ack_low_out == s_reg.gpio[1]);
   endproperty
   a_gpio_mode: assert property (p_gpio_mode) else $error("ack pins not general i/o");

   property p_ack_drive;
      @(posedge aclk) disable iff (!aresetn)
      (s_reg.pin_assign && (size_ack_high_oe || size_ack_low_oe)) |-> cycle_done && cycle_hit;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("ack driven outside termination");
endmodule : csd_chip_select_decode

//--- rtl/csd_pkg.sv
// constants, types and helpers for the chip-select address decoder
package csd_pkg;
   localparam int CSD_ADDR_W = 24;
   localparam int CSD_FIELD_W = 13;
   localparam int CSD_CODE_LSB = 0;
   localparam int CSD_CODE_W = 3;
   localparam int CSD_FIELD_LSB = 3;
   localparam int CSD_ADDR_CMP_LSB = 11;
   localparam int CSD_WAIT_LSB = 0;
   localparam int CSD_WAIT_W = 4;
   localparam int CSD_PORT16_BIT = 4;
   localparam int CSD_ENABLE_BIT = 5;
   localparam int CSD_SIZE_ACK_FN_BIT = 0;
   localparam int CSD_GPIO_OUT_LSB = 0;
   localparam int CSD_GPIO_DIR_LSB = 2;
   localparam int CSD_AXI_ADDR_W = 12;
   localparam int CSD_CS_IDX_LSB = 3;
   localparam logic [11:0] CSD_BASE_OFS = 12'h000;
   localparam logic [11:0] CSD_OPT_OFS = 12'h004;
   localparam logic [11:0] CSD_CS_STRIDE = 12'h008;
   localparam logic [11:0] CSD_PIN_ASSIGN_OFS = 12'h100;
   localparam logic [11:0] CSD_GPIO_OFS = 12'h104;
   localparam logic [11:0] CSD_STATUS_OFS = 12'h108;
   localparam logic [11:0] CSD_MATCH_OFS = 12'h10c;
   localparam logic [15:0] CSD_BASE_RST = 16'h0000;
   localparam logic [15:0] CSD_OPT_RST = 16'h0000;
   localparam logic [3:0] CSD_GPIO_RST = 4'h0;
   localparam logic [3:0] CSD_WAIT_MAX = 4'hf;
   localparam logic [1:0] CSD_RESP_OKAY = 2'h0;

   typedef enum logic [1:0] {CSD_IDLE = 2'b01, CSD_ACTIVE = 2'b10} csd_cycle_type;

   typedef struct packed {
      logic en;
      logic [CSD_AXI_ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } csd_wreq_type;

   typedef struct packed {
      logic en;
      logic [CSD_AXI_ADDR_W-1:0] addr;
   } csd_rreq_type;

   // compare mask over address bits 23..11 for a block-size code
   function automatic logic [CSD_FIELD_W-1:0] csd_field_mask(input logic [CSD_CODE_W-1:0] code);
      case (code)
         3'h0: csd_field_mask = 13'h1fff;
         3'h1: csd_field_mask = 13'h1ffc;
         3'h2: csd_field_mask = 13'h1ff8;
         3'h3: csd_field_mask = 13'h1fe0;
         3'h4: csd_field_mask = 13'h1fc0;
         3'h5: csd_field_mask = 13'h1f80;
         3'h6: csd_field_mask = 13'h1f00;
         default: csd_field_mask = 13'h1e00;
      endcase
   endfunction : csd_field_mask

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] csd_apply_strb(input logic [15:0] old_val, input logic [31:0] data,
                                                  input logic [3:0] strb);
      csd_apply_strb = old_val;
      if (strb[0])
      begin
         csd_apply_strb[7:0] = data[7:0];
      end
      if (strb[1])
      begin
         csd_apply_strb[15:8] = data[15:8];
      end
   endfunction : csd_apply_strb
endpackage : csd_pkg

//--- verif/chip_select_address_decode_test.sv
// self-checking bench for the chip-select decoder
`timescale 1ns/1ps
module chip_select_address_decode_test
   import csd_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, cycle_done, cycle_hit;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic cycle_start = 1'b0;
   logic [23:0] cycle_addr = '0;
   logic [11:0] cs_n;
   logic strap_low = 1'b0;
   logic strap_pin, hi_line, lo_line, hi_out, hi_oe, lo_out, lo_oe;
   int err_total = 0;
   int checks_done = 0;
   localparam logic [23:0] BLK [8] = '{24'h00_0800, 24'h00_2000, 24'h00_4000, 24'h01_0000,
                                       24'h02_0000, 24'h04_0000, 24'h08_0000, 24'h10_0000};

   csd_chip_select_decode #(.CS_COUNT(12)) i_csd_chip_select_decode (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cycle_start(cycle_start), .cycle_addr(cycle_addr), .chip_select_n(cs_n),
      .cycle_done(cycle_done), .cycle_hit(cycle_hit), .reset_config_line_eight(strap_pin),
      .size_ack_high_in(hi_line), .size_ack_high_out(hi_out), .size_ack_high_oe(hi_oe),
      .size_ack_low_in(lo_line), .size_ack_low_out(lo_out), .size_ack_low_oe(lo_oe));

   csd_far_side i_csd_far_side (.strap_low(strap_low), .size_ack_high_out(hi_out),
      .size_ack_high_oe(hi_oe), .size_ack_low_out(lo_out), .size_ack_low_oe(lo_oe),
      .size_ack_high_line(hi_line), .size_ack_low_line(lo_line), .reset_config_line_eight(strap_pin));

   always #2 aclk = ~aclk;

   task automatic end_sim();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic do_reset(input logic low);
      @(posedge aclk);
      aresetn <= 1'b0;
      strap_low <= low;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && awready)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      check(bresp, 32'(CSD_RESP_OKAY));
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      d = rdata;
      rready <= 1'b0;
      check(rresp, 32'(CSD_RESP_OKAY));
   endtask : axi_rd

   task automatic rd_check(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] d;
      axi_rd(a, d);
      check(d & mask, exp);
   endtask : rd_check

   // one bus cycle: cycles to done, hit flag and selects seen low
   task automatic run_cycle(input logic [23:0] a, input logic [31:0] exp_n, input logic exp_hit,
                            input logic [11:0] exp_cs, input logic [1:0] exp_ack);
      int n;
      logic [11:0] low_seen;
      n = 0;
      low_seen = '0;
      @(posedge aclk);
      cycle_addr <= a;
      cycle_start <= 1'b1;
      @(posedge aclk);
      cycle_start <= 1'b0;
      do
      begin
         @(posedge aclk);
         n++;
         low_seen |= ~cs_n;
      end
      while (!cycle_done && n < 40);
      check(n, exp_n);
      check(cycle_hit, exp_hit);
      check(low_seen, exp_cs);
      check({hi_line, lo_line}, 32'(exp_ack));
   endtask : run_cycle

   task automatic t_regs();
      rd_check(12'h000, 32'hffff_ffff, 32'h0000_0000);
      rd_check(12'h100, 32'h0000_0001, 32'h0000_0001);
      axi_wr(12'h000, 32'h0000_0504);
      rd_check(12'h000, 32'hffff_ffff, 32'h0000_0404);
      axi_wr(12'h008, 32'hffff_ffff);
      rd_check(12'h008, 32'hffff_ffff, 32'h0000_f007);
      rd_check(12'h200, 32'hffff_ffff, 32'h0000_0000);
   endtask : t_regs

   task automatic t_sizes();
      axi_wr(12'h00c, 32'h0000_0020);
      for (int c = 0; c < 8; c++)
      begin
         axi_wr(12'h008, 32'h0000_8000 | 32'(c));
         run_cycle(24'h80_0000 + BLK[c] - 24'h00_0001, 2, 1'b1, 12'h002, 2'b10);
         run_cycle(24'h80_0000 + BLK[c], 2, 1'b0, 12'h000, 2'b11);
      end
      axi_wr(12'h00c, 32'h0000_0000);
   endtask : t_sizes

   task automatic t_overlap();
      axi_wr(12'h000, 32'h0000_0504);
      axi_wr(12'h004, 32'h0000_0023);
      axi_wr(12'h050, 32'h0000_0400);
      axi_wr(12'h054, 32'h0000_003c);
      run_cycle(24'h04_0000, 5, 1'b1, 12'h401, 2'b01);
      run_cycle(24'h05_0000, 5, 1'b1, 12'h001, 2'b10);
      axi_wr(12'h004, 32'h0000_002f);
      run_cycle(24'h04_0000, 14, 1'b1, 12'h401, 2'b01);
      axi_wr(12'h004, 32'h0000_0000);
      run_cycle(24'h05_0000, 2, 1'b0, 12'h000, 2'b11);
      run_cycle(24'h04_0000, 14, 1'b1, 12'h400, 2'b01);
      rd_check(12'h10c, 32'h0000_0fff, 32'h0000_0400);
      rd_check(12'h108, 32'h0000_0003, 32'h0000_0002);
   endtask : t_overlap

   task automatic t_strap();
      do_reset(1'b1);
      rd_check(12'h100, 32'h0000_0001, 32'h0000_0000);
      axi_wr(12'h104, 32'h0000_0008);
      repeat (4) @(posedge aclk);
      check({lo_oe, lo_out, hi_oe, hi_out}, 32'h0000_0008);
      rd_check(12'h108, 32'h0000_000f, 32'h0000_0004);
      axi_wr(12'h100, 32'h0000_0001);
      rd_check(12'h100, 32'h0000_0001, 32'h0000_0001);
   endtask : t_strap

   initial
   begin
      do_reset(1'b0);
      t_regs();
      t_sizes();
      t_overlap();
      t_strap();
      end_sim();
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      err_total++;
      end_sim();
   end
endmodule : chip_select_address_decode_test

//--- verif/csd_far_side.sv
// far-side model: pulled-up ack lines and reset strap
`timescale 1ns/1ps
module csd_far_side
   import csd_pkg::*;
(
   input wire logic strap_low,
   input wire logic size_ack_high_out,
   input wire logic size_ack_high_oe,
   input wire logic size_ack_low_out,
   input wire logic size_ack_low_oe,
   output logic size_ack_high_line,
   output logic size_ack_low_line,
   output logic reset_config_line_eight
);
   // pull-ups hold undriven acks high
   assign size_ack_high_line = size_ack_high_oe ? size_ack_high_out : 1'b1;
   assign size_ack_low_line = size_ack_low_oe ? size_ack_low_out : 1'b1;
   // strap held low selects general i/o
   assign reset_config_line_eight = !strap_low;
endmodule : csd_far_side
